// File: bsr_boundary_reg.sv
// Boundary-scan data register: capture/shift/update chain and output muxing
`timescale 1ns/1ps
`default_nettype none
module bsr_boundary_reg
   import bsr_pkg::*;
(
   // System clock domain
   input  wire logic            mclk_i,
   input  wire logic            rst_i,
   // Test clock domain, driven by the tap controller
   input  wire logic            tck_i,
   input  wire logic            trst_i,
   input  wire logic            tdi_i,
   output logic                 tdo_o,
   input  wire logic            dr_select_i,
   input  wire logic            capture_dr_i,
   input  wire logic            shift_dr_i,
   input  wire logic            update_dr_i,
   input  wire bsr_pkg::bsr_mode_e mode_i,
   // Functional side
   input  wire bsr_pkg::bsr_drive_s core_i,
   input  wire bsr_pkg::bsr_pins_s  pins_i,
   output bsr_pkg::bsr_drive_s      drive_o,
   output logic                 test_active_o
);
   import bsr_pkg::*;

   //===========================================================================
   // Cell map check
   // Cell positions live in the package; a gap or overlap among the address, data and write
   // cells or the port cells would silently misplace every later cell, so elaboration stops instead
   if (PORT_CELLS != 2*PORT_W) begin : g_bad_port_cells
      $error("Port cells must be two per pin");
   end
   if (CELL_PORT0 + NUM_PORTS*PORT_CELLS != CHAIN_LEN) begin : g_bad_chain_len
      $error("Port cells do not close the chain");
   end
   if (CELL_DATA != CELL_ADDR + BUS_W || CELL_WR != CELL_DATA + BUS_W) begin : g_bad_bus_cells
      $error("Bus cells overlap or leave a gap");
   end

   //===========================================================================
   // Chain in the test clock domain
   logic [CHAIN_LEN-1:0] shift_q, shift_d;
   logic [CHAIN_LEN-1:0] upd_q, upd_d;
   logic                 ext_q, ext_d;
   logic [CHAIN_LEN-1:0] cap_v;
   logic                 tdo_q, tdo_d;

   always_comb begin
      cap_v                                  = '0;
      cap_v[CELL_RST_EN]                     = core_i.rst_en;             // RL4
      cap_v[CELL_RST_IO]                     = pins_i.rst_pin_in;         // RL5
      cap_v[CELL_XTAL]                       = pins_i.crystal_input_pin;  // RL6
      cap_v[CELL_WPU]                        = core_i.wpu_en;             // RL7
      cap_v[CELL_ADDR +: BUS_W]              = core_i.periph_addr_bit;    // RL8
      cap_v[CELL_DATA +: BUS_W]              = core_i.periph_data_bit;    // RL9
      cap_v[CELL_WR]                         = core_i.wr_strobe;          // RL10
      cap_v[CELL_RD]                         = core_i.rd_strobe;          // RL11
      cap_v[CELL_RMW]                        = core_i.rmw_strobe;         // RL12
      for (int n = 0; n < NUM_PORTS*PORT_W; n++) begin
         // Port p pin k sits at 23+16p+2k; flat index n = 8p+k gives 23+2n
         cap_v[CELL_PORT0 + 2*n]     = core_i.port_oe[n];    // RL13 RL14 RL15 RL16
         cap_v[CELL_PORT0 + 2*n + 1] = pins_i.port_in[n];    // RL13 RL14 RL15 RL16
      end
   end

   //===========================================================================
   // Capture sources entering the test clock domain
   // Pins and core values are asynchronous to tck, so two stages guard every
   // capture cell. Limitation: tck only runs during frames, so a source is
   // seen only after two tck edges, as the controller gives on its way to capture.
   logic [CHAIN_LEN-1:0] cap_s1_q, cap_s2_q;

   always_ff @(posedge tck_i) begin
      cap_s1_q <= cap_v;
      cap_s2_q <= cap_s1_q;
   end

   always_comb begin
      shift_d = shift_q;
      upd_d   = upd_q;
      ext_d   = ext_q;
      tdo_d   = tdo_q;
      if (dr_select_i && capture_dr_i) begin
         shift_d = cap_s2_q;                                // RL17 RL2 RL3
      end else if (dr_select_i && shift_dr_i) begin
         shift_d = {tdi_i, shift_q[CHAIN_LEN-1:1]};         // RL1
      end
      if (dr_select_i && shift_dr_i) begin
         tdo_d = shift_q[0];
      end
      // Only external test latches new values; sample leaves drives alone
      if (dr_select_i && update_dr_i && mode_i == BSR_EXTEST) begin
         upd_d = shift_q;                                   // RL17 RL2
      end
      ext_d = (mode_i == BSR_EXTEST);                       // RL3 RL18
   end

   always_ff @(posedge tck_i) begin
      if (trst_i) begin
         shift_q <= '0;
         upd_q   <= '0;
         ext_q   <= 1'b0;
         tdo_q   <= 1'b0;
      end else begin
         shift_q <= shift_d;
         upd_q   <= upd_d;
         ext_q   <= ext_d;
         tdo_q   <= tdo_d;
      end
   end

   // Tdo changes on the rising edge here; a real tap retimes it to the falling edge
   assign tdo_o = tdo_q;

   //===========================================================================
   // Crossing into the system domain
   // Update cells change only in Update-DR, long after shifting, so a two-stage
   // synchroniser per bit is adequate; brief skew across bits is accepted.
   logic [CHAIN_LEN-1:0] upd_s1_q, upd_s2_q;
   logic                 ext_s1_q, ext_s2_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         upd_s1_q <= '0;
         upd_s2_q <= '0;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
      end else begin
         upd_s1_q <= upd_q;
         upd_s2_q <= upd_s1_q;
         ext_s1_q <= ext_q;
         ext_s2_q <= ext_s1_q;
      end
   end

   //===========================================================================
   // Output selection, registered
   bsr_drive_s drv_q, drv_d, tst_v;

   always_comb begin
      tst_v                  = '0;
      tst_v.rst_en           = upd_s2_q[CELL_RST_EN];            // RL4
      tst_v.rst_out          = upd_s2_q[CELL_RST_IO];            // RL5
      tst_v.wpu_en           = upd_s2_q[CELL_WPU];               // RL7
      tst_v.periph_addr_bit  = upd_s2_q[CELL_ADDR +: BUS_W];     // RL8
      tst_v.periph_data_bit  = upd_s2_q[CELL_DATA +: BUS_W];     // RL9
      tst_v.wr_strobe        = upd_s2_q[CELL_WR];                // RL10
      tst_v.rd_strobe        = upd_s2_q[CELL_RD];                // RL11
      tst_v.rmw_strobe       = upd_s2_q[CELL_RMW];               // RL12
      for (int n = 0; n < NUM_PORTS*PORT_W; n++) begin
         tst_v.port_oe[n]  = upd_s2_q[CELL_PORT0 + 2*n];        // RL13 RL14 RL15 RL16
         tst_v.port_out[n] = upd_s2_q[CELL_PORT0 + 2*n + 1];    // RL13 RL14 RL15 RL16
      end
      drv_d = ext_s2_q ? tst_v : core_i;                         // RL2 RL3 RL18
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         drv_q <= '0;
      end else begin
         drv_q <= drv_d;
      end
   end

   assign drive_o       = drv_q;
   assign test_active_o = ext_s2_q;

   //===========================================================================
   // Checks
   sequence s_cap;
      dr_select_i && capture_dr_i;
   endsequence

   sequence s_upd;
      dr_select_i && update_dr_i && !capture_dr_i;
   endsequence

   sequence s_test;
      ext_s2_q;
   endsequence

   AST_CAPTURE_LOADS: assert property (@(posedge tck_i) disable iff (trst_i) // RL17
      s_cap |=> shift_q == $past(cap_s2_q))
      else $error("Capture did not load the chain");

   AST_SHIFT_MOVES: assert property (@(posedge tck_i) disable iff (trst_i) // RL1
      dr_select_i && shift_dr_i && !capture_dr_i |=>
         shift_q[CHAIN_LEN-1] == $past(tdi_i) && tdo_o == $past(shift_q[0]))
      else $error("Shift did not advance the chain");

   AST_EXTEST_UPDATE: assert property (@(posedge tck_i) disable iff (trst_i) // RL2
      s_upd ##0 (mode_i == BSR_EXTEST) |=> upd_q == $past(shift_q))
      else $error("External test update did not latch the chain");

   AST_SAMPLE_HOLD: assert property (@(posedge tck_i) disable iff (trst_i) // RL3
      mode_i != BSR_EXTEST |=> upd_q == $past(upd_q))
      else $error("Update stage changed outside external test");

   AST_PASS_THROUGH: assert property (@(posedge mclk_i) disable iff (rst_i) // RL18
      !ext_s2_q |=> drive_o == $past(core_i))
      else $error("Functional signals not passed through");

   AST_DRIVE_RESET_CELLS: assert property (@(posedge mclk_i) disable iff (rst_i) // RL4
      ext_s2_q |=> drive_o.rst_en == $past(upd_s2_q[CELL_RST_EN])
                && drive_o.rst_out == $past(upd_s2_q[CELL_RST_IO]))
      else $error("Reset cells not driven in external test");

   AST_DRIVE_BUS: assert property (@(posedge mclk_i) disable iff (rst_i) // RL8
      ext_s2_q |=> drive_o.periph_addr_bit == $past(upd_s2_q[CELL_ADDR +: BUS_W])
                && drive_o.rmw_strobe == $past(upd_s2_q[CELL_RMW]))
      else $error("Peripheral bus not driven from cells");

   AST_DRIVE_PORT3: assert property (@(posedge mclk_i) disable iff (rst_i) // RL16
      ext_s2_q |=> drive_o.port_out[31] == $past(upd_s2_q[CHAIN_LEN-1])
                && drive_o.port_oe[24] == $past(upd_s2_q[71]))
      else $error("Port three cells misplaced");

   AST_XTAL_CAPTURE: assert property (@(posedge tck_i) disable iff (trst_i) // RL6
      s_cap |=> shift_q[CELL_XTAL] == $past(pins_i.crystal_input_pin, 3))
      else $error("Crystal cell did not capture the pin");

   AST_SYNC_CAPTURE: assert property (@(posedge tck_i) disable iff (trst_i) // RL17
      cap_s2_q == $past(cap_v, 2))
      else $error("Capture sources not passed through two stages");

   AST_IDLE_HOLDS_CHAIN: assert property (@(posedge tck_i) disable iff (trst_i) // RL1
      !dr_select_i |=> shift_q == $past(shift_q))
      else $error("Chain moved while not selected");

   AST_TDO_HOLDS: assert property (@(posedge tck_i) disable iff (trst_i) // RL1
      !(dr_select_i && shift_dr_i) |=> $stable(tdo_o))
      else $error("Serial output changed outside shifting");

   AST_UPDATE_ONLY_IN_UPDATE: assert property (@(posedge tck_i) disable iff (trst_i) // RL17
      !(dr_select_i && update_dr_i) |=> upd_q == $past(upd_q))
      else $error("Update stage changed outside Update-DR");

   AST_SAMPLE_NO_DRIVE: assert property (@(posedge tck_i) disable iff (trst_i) // RL3 RL18
      mode_i != BSR_EXTEST |=> !ext_q)
      else $error("Test drive armed outside external test");

   AST_EXTEST_ARMS: assert property (@(posedge tck_i) disable iff (trst_i) // RL2
      mode_i == BSR_EXTEST |=> ext_q)
      else $error("Test drive not armed in external test");

   AST_CAPTURE_CORE_CELLS: assert property (@(posedge tck_i) disable iff (trst_i) // RL4 RL7
      s_cap |=> shift_q[CELL_RST_EN] == $past(core_i.rst_en, 3)
             && shift_q[CELL_WPU] == $past(core_i.wpu_en, 3))
      else $error("Reset or pullup enable cell did not capture");

   AST_CAPTURE_RST_PIN: assert property (@(posedge tck_i) disable iff (trst_i) // RL5
      s_cap |=> shift_q[CELL_RST_IO] == $past(pins_i.rst_pin_in, 3))
      else $error("Reset pin cell did not capture");

   AST_CAPTURE_BUS: assert property (@(posedge tck_i) disable iff (trst_i) // RL8 RL9
      s_cap |=> shift_q[CELL_ADDR +: BUS_W] == $past(core_i.periph_addr_bit, 3)
             && shift_q[CELL_DATA +: BUS_W] == $past(core_i.periph_data_bit, 3))
      else $error("Peripheral address or data cells did not capture");

   AST_CAPTURE_STROBES: assert property (@(posedge tck_i) disable iff (trst_i) // RL10 RL11 RL12
      s_cap |=> shift_q[CELL_WR] == $past(core_i.wr_strobe, 3)
             && shift_q[CELL_RD] == $past(core_i.rd_strobe, 3)
             && shift_q[CELL_RMW] == $past(core_i.rmw_strobe, 3))
      else $error("Strobe cells did not capture");

   AST_CAPTURE_PORT_EDGE: assert property (@(posedge tck_i) disable iff (trst_i) // RL13 RL16
      s_cap |=> shift_q[CELL_PORT0] == $past(core_i.port_oe[0], 3)
             && shift_q[CHAIN_LEN-1] == $past(pins_i.port_in[NUM_PORTS*PORT_W-1], 3))
      else $error("Port end cells did not capture");

   AST_DRIVE_WPU: assert property (@(posedge mclk_i) disable iff (rst_i) // RL7
      s_test |=> drive_o.wpu_en == $past(upd_s2_q[CELL_WPU]))
      else $error("Pullup enable not driven from its cell");

   AST_DRIVE_DATA: assert property (@(posedge mclk_i) disable iff (rst_i) // RL9
      s_test |=> drive_o.periph_data_bit == $past(upd_s2_q[CELL_DATA +: BUS_W]))
      else $error("Peripheral data not driven from cells");

   AST_DRIVE_STROBES: assert property (@(posedge mclk_i) disable iff (rst_i) // RL10 RL11
      s_test |=> drive_o.wr_strobe == $past(upd_s2_q[CELL_WR])
              && drive_o.rd_strobe == $past(upd_s2_q[CELL_RD]))
      else $error("Strobes not driven from cells");

   AST_DRIVE_PORT0: assert property (@(posedge mclk_i) disable iff (rst_i) // RL13
      s_test |=> drive_o.port_oe[0] == $past(upd_s2_q[CELL_PORT0])
              && drive_o.port_out[PORT_W-1] == $past(upd_s2_q[CELL_PORT0 + PORT_CELLS - 1]))
      else $error("Port zero cells misplaced");

   AST_DRIVE_PORT1: assert property (@(posedge mclk_i) disable iff (rst_i) // RL14
      s_test |=> drive_o.port_oe[PORT_W] == $past(upd_s2_q[CELL_PORT0 + PORT_CELLS])
              && drive_o.port_out[2*PORT_W-1] == $past(upd_s2_q[CELL_PORT0 + 2*PORT_CELLS - 1]))
      else $error("Port one cells misplaced");

   AST_DRIVE_PORT2: assert property (@(posedge mclk_i) disable iff (rst_i) // RL15
      s_test |=> drive_o.port_oe[2*PORT_W] == $past(upd_s2_q[CELL_PORT0 + 2*PORT_CELLS])
              && drive_o.port_out[3*PORT_W-1] == $past(upd_s2_q[CELL_PORT0 + 3*PORT_CELLS - 1]))
      else $error("Port two cells misplaced");

   AST_RESET_CLEARS: assert property (@(posedge mclk_i)
      rst_i |=> drive_o == '0 && !test_active_o)
      else $error("System reset did not clear the drives");

   // Every pin, so a swapped pair anywhere among the port cells is caught
   for (genvar n = 0; n < NUM_PORTS*PORT_W; n++) begin : g_pin_chk
      AST_DRIVE_PIN: assert property (@(posedge mclk_i) disable iff (rst_i) // RL13 RL14 RL15 RL16
         s_test |=> drive_o.port_oe[n] == $past(upd_s2_q[CELL_PORT0 + 2*n])
                 && drive_o.port_out[n] == $past(upd_s2_q[CELL_PORT0 + 2*n + 1]))
         else $error("Pin cells not driven to their pin");
   end
endmodule
`default_nettype wire

// File: bsr_pkg.sv
// Package for the boundary-scan data register: cell map, types and sizes
//==============================================================================
// Functional notes
// RL1 - Single 87-cell shift chain between tdi and tdo
// RL2 - External test mode captures and updates
// RL3 - Sample mode captures only, never drives
// RL4 - Cell 0: reset enable capture and drive
// RL5 - Cell 1: reset pin input and output
// RL6 - Cell 2: crystal input capture, no update
// RL7 - Cell 3: weak pullup enable capture/drive
// RL8 - Cells 4-11: peripheral address bits, LSB first
// RL9 - Cells 12-19: peripheral data bits, LSB first
// RL10 - Cell 20: peripheral write strobe
// RL11 - Cell 21: peripheral read strobe
// RL12 - Cell 22: peripheral read-modify-write strobe
// RL13 - Port zero cells 23-38, enable then data
// RL14 - Port one cells 39-54, enable then data
// RL15 - Port two cells 55-70, enable then data
// RL16 - Port three cells 71-86, enable then data
// RL17 - Capture in Capture-DR, update in Update-DR
// RL18 - Without update mode, functional signals pass through
package bsr_pkg;
   localparam int unsigned CHAIN_LEN    = 87;
   localparam int unsigned CELL_RST_EN  = 0;
   localparam int unsigned CELL_RST_IO  = 1;
   localparam int unsigned CELL_XTAL    = 2;
   localparam int unsigned CELL_WPU     = 3;
   localparam int unsigned CELL_ADDR    = 4;
   localparam int unsigned CELL_DATA    = 12;
   localparam int unsigned CELL_WR      = 20;
   localparam int unsigned CELL_RD      = 21;
   localparam int unsigned CELL_RMW     = 22;
   localparam int unsigned CELL_PORT0   = 23;
   localparam int unsigned PORT_CELLS   = 16;
   localparam int unsigned NUM_PORTS    = 4;
   localparam int unsigned PORT_W       = 8;
   localparam int unsigned BUS_W        = 8;

   // Signals of the peripheral register bus and the pins, core or pin side
   typedef struct packed {
      logic                 rst_en;
      logic                 rst_out;
      logic                 wpu_en;
      logic [BUS_W-1:0]     periph_addr_bit;
      logic [BUS_W-1:0]     periph_data_bit;
      logic                 wr_strobe;
      logic                 rd_strobe;
      logic                 rmw_strobe;
      logic [NUM_PORTS*PORT_W-1:0] port_oe;
      logic [NUM_PORTS*PORT_W-1:0] port_out;
   } bsr_drive_s;

   typedef struct packed {
      logic                 rst_pin_in;
      logic                 crystal_input_pin;
      logic [NUM_PORTS*PORT_W-1:0] port_in;
   } bsr_pins_s;

   typedef enum logic [1:0] {
      BSR_BYPASS = 2'b00,
      BSR_SAMPLE = 2'b01,
      BSR_EXTEST = 2'b11
   } bsr_mode_e;
endpackage

// File: bsr_tap_model.sv
// Test controller model driving the test-clock side of the scan chain
`timescale 1ns/1ps
`default_nettype none
module bsr_tap_model
   import bsr_pkg::*;
(
   // Test port
   output logic                tck_o,
   output logic                trst_o,
   output logic                tdi_o,
   input  wire logic           tdo_i,
   output logic                dr_select_o,
   output logic                capture_dr_o,
   output logic                shift_dr_o,
   output logic                update_dr_o,
   output bsr_pkg::bsr_mode_e  mode_o
);
   import bsr_pkg::*;
   //=====================
   // Frames
   initial begin
      tck_o = 1'b0;
      trst_o = 1'b1;
      tdi_o = 1'b1;
      dr_select_o = 1'b0;
      capture_dr_o = 1'b0;
      shift_dr_o = 1'b0;
      update_dr_o = 1'b0;
      mode_o = BSR_BYPASS;
   end
   // Clock stands still between frames, so only ticks move the chain
   task automatic tick();
      #15 tck_o = 1'b1;
      #15 tck_o = 1'b0;
   endtask
   task automatic reset();
      trst_o = 1'b1;
      tick();
      tick();
      trst_o = 1'b0;
   endtask
   task automatic scan(input bsr_mode_e m, input logic [86:0] din, output logic [86:0] dout);
      mode_o = m;
      dr_select_o = 1'b1;
      // Idle and select states before capture also feed the capture synchroniser
      tick();
      tick();
      capture_dr_o = 1'b1;
      tick();
      capture_dr_o = 1'b0;
      shift_dr_o = 1'b1;
      for (int i = 0; i < CHAIN_LEN; i++) begin
         tdi_o = din[i];
         tick();
         dout[i] = tdo_i;
      end
      shift_dr_o = 1'b0;
      tdi_o = 1'b1;
      update_dr_o = 1'b1;
      tick();
      update_dr_o = 1'b0;
      dr_select_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the boundary-scan data register
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bsr_pkg::*;
   logic        mclk_i, rst_i, tck, trst, tdi, tdo, dsel, cap, sh, upd, test_active;
   bsr_mode_e   mode;
   bsr_drive_s  core, drive;
   bsr_pins_s   pins;
   logic [31:0] seed = 32'h0000a657;
   logic [127:0] r;
   logic [86:0] vin, vout;
   int          bad_count = 0;
   int          comparisons = 0;
   //=====================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [86:0] cap_vec(input bsr_drive_s c, input bsr_pins_s p);
      logic [86:0] v;
      v[3:0] = {c.wpu_en, p.crystal_input_pin, p.rst_pin_in, c.rst_en};
      v[11:4] = c.periph_addr_bit;
      v[19:12] = c.periph_data_bit;
      v[22:20] = {c.rmw_strobe, c.rd_strobe, c.wr_strobe};
      for (int n = 0; n < 32; n++) begin
         v[23+2*n] = c.port_oe[n];
         v[24+2*n] = p.port_in[n];
      end
      return v;
   endfunction
   function automatic bsr_drive_s upd_drv(input logic [86:0] v);
      bsr_drive_s d;
      {d.wpu_en, d.rst_out, d.rst_en} = {v[3], v[1], v[0]};
      d.periph_addr_bit = v[11:4];
      d.periph_data_bit = v[19:12];
      {d.rmw_strobe, d.rd_strobe, d.wr_strobe} = v[22:20];
      for (int n = 0; n < 32; n++) begin
         d.port_oe[n] = v[23+2*n];
         d.port_out[n] = v[24+2*n];
      end
      return d;
   endfunction
   task automatic cmp(input logic [127:0] got, input logic [127:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t: %s", $time, msg);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   //=====================
   // Design and far side
   bsr_boundary_reg i_bsr_boundary_reg (.mclk_i(mclk_i), .rst_i(rst_i), .tck_i(tck),
      .trst_i(trst), .tdi_i(tdi), .tdo_o(tdo), .dr_select_i(dsel), .capture_dr_i(cap),
      .shift_dr_i(sh), .update_dr_i(upd), .mode_i(mode), .core_i(core), .pins_i(pins),
      .drive_o(drive), .test_active_o(test_active));
   bsr_tap_model i_bsr_tap_model (.tck_o(tck), .trst_o(trst), .tdi_o(tdi), .tdo_i(tdo),
      .dr_select_o(dsel), .capture_dr_o(cap), .shift_dr_o(sh), .update_dr_o(upd),
      .mode_o(mode));
   always #10 mclk_i = ~mclk_i;
   // Hang guard
   initial begin
      #1000000;
      bad_count++;
      $display("FAIL %0t: run did not finish", $time);
      test_done();
   end
   //=====================
   // Scenarios
   initial begin
      mclk_i = 1'b0;
      rst_i = 1'b1;
      core = '0;
      pins = '0;
      step(4);
      rst_i = 1'b0;
      i_bsr_tap_model.reset();
      for (int it = 0; it < 6; it++) begin
         r = {rnd(), rnd(), rnd(), rnd()};
         core = r[85:0];
         pins = r[119:86];
         r = {rnd(), rnd(), rnd(), rnd()};
         vin = (it == 0) ? '1 : (it == 1) ? '0 : r[86:0];
         step(3);
         cmp(drive, core, "pass-through differs");
         i_bsr_tap_model.scan(BSR_SAMPLE, vin, vout);
         cmp(vout, cap_vec(core, pins), "sample capture");
         step(6);
         cmp(drive, core, "sample changed outputs");
         i_bsr_tap_model.scan(BSR_EXTEST, vin, vout);
         cmp(vout, cap_vec(core, pins), "extest capture");
         step(6);
         cmp(drive, upd_drv(vin), "extest update");
         cmp(test_active, 1'b1, "test drive not active");
         if (it == 2) begin
            rst_i = 1'b1;
            step(2);
            cmp(drive, '0, "reset did not clear drives");
            cmp(test_active, 1'b0, "reset left test drive active");
            rst_i = 1'b0;
            step(6);
            cmp(drive, upd_drv(vin), "update lost after reset");
         end
         i_bsr_tap_model.scan(BSR_BYPASS, ~vin, vout);
         step(6);
         cmp(drive, core, "bypass changed outputs");
         cmp(test_active, 1'b0, "test drive still active");
      end
      test_done();
   end
endmodule
`default_nettype wire
